/* hw/swd_slave_controller.sv */
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
// Functional notes
// - expired watchdog forces outputs to safe value
// - two independent watchdogs, 100 ms default
// - shared tick multiplier at 400h
// - own timer counts at 410h, 420h
// - master downloads settings only when enabled
// - bus watchdog restarts on process-data access
// - bus watchdog expiry leaves state untouched
// - bus expiry holds until next access
// - local watchdog trips without local access
// - tick is multiplier plus two base ticks
// - defaults: multiplier 2498, bus count 1000
// - bus timer zero disables that watchdog
// - five states, master drives transitions
// - init after reset, no exchange
// - init to preop checks mailbox channels
// - preop allows mailbox, no process data
// - preop to safe_operational_state checks, copies inputs
// - safe_operational_state exchanges data, outputs stay safe
// - disabled bus watchdog lets safe_operational_state outputs switch
// - master sends outputs before op request
// - op copies master data to outputs
// - boot only from init, file transfer only
module swd_slave_controller
	import swd_pkg::*;
#(
	parameter logic [15:0] MULT_RESET = MULT_RST,
	parameter logic [15:0] BUS_WD_RESET = BUS_WD_RST,
	parameter logic [15:0] LPI_WD_RESET = LPI_WD_RST
)
(
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_I,
	// link from the bus master
	swd_if.device LINK,
	// local process side
	input wire logic [PD_W-1:0] IN_I,
	input wire logic LPI_ACCESS_I,
	output logic [PD_W-1:0] OUT_O,
	// status
	output swd_state_type STATE_O,
	output logic MBX_EN_O,
	output logic FILE_XFER_ONLY_O,
	output logic PD_EN_O,
	output logic BUS_WD_EXP_O,
	output logic LPI_WD_EXP_O
);
	logic [15:0] mult_q, lpi_wd_q, bus_wd_q;
	logic [2:0] sync_cfg_q;
	logic [PD_W-1:0] safe_val_q, out_data_q, pd_in_q;
	logic [PD_W-1:0] in_s1_q, in_s2_q;
	logic [16:0] pre_q;
	logic [15:0] bus_cnt_q, lpi_cnt_q;
	logic bus_exp_q, lpi_exp_q, req_err_q;
	swd_state_type state_q;

	// next count of one watchdog: restart on access, saturate once expired
	function automatic logic [15:0] wd_next(input logic [15:0] cnt, input logic kick,
		input logic tick, input logic expd);
		if (kick)
			wd_next = 16'h0000;
		else if (tick && !expd)
			wd_next = cnt + 16'h0001;
		else
			wd_next = cnt;
	endfunction

	// expiry flag: access clears it, a zero timer keeps it off;
	// a count already past a lowered timer trips on the next tick
	function automatic logic wd_exp(input logic [15:0] cnt, input logic [15:0] tmr,
		input logic kick, input logic tick, input logic expd);
		if (kick || tmr == 16'h0000)
			wd_exp = 1'b0;
		else
			wd_exp = expd || (tick && cnt >= tmr - 16'h0001);
	endfunction

	// register write decode
	wire wr_mult = LINK.reg_we && LINK.reg_addr == REG_MULT;
	wire wr_lpi = LINK.reg_we && LINK.reg_addr == REG_LPI_WD;
	wire wr_bus = LINK.reg_we && LINK.reg_addr == REG_BUS_WD;
	wire wr_sync = LINK.reg_we && LINK.reg_addr == REG_SYNC_CFG;
	wire wr_safe = LINK.reg_we && LINK.reg_addr == REG_SAFE_VAL;

	// exchange permissions per state
	// nothing allowed in init
	wire pd_ok = state_q == ST_SAFE_OPERATIONAL_STATE || state_q == ST_OP;
	wire mbx_ok = state_q == ST_PREOP || pd_ok;
	wire bus_kick = LINK.pd_wr && pd_ok;
	wire lpi_kick = LPI_ACCESS_I;

	wire [16:0] tick_len = {1'b0, mult_q} + TICK_EXTRA;
	wire tick = pre_q == tick_len - 17'h00001;

	// transition legality
	wire mbx_cfg_ok = sync_cfg_q[SYNC_CH0_BIT] && sync_cfg_q[SYNC_CH1_BIT];
	wire pd_cfg_ok = sync_cfg_q[SYNC_CH2_BIT];
	wire req_new = LINK.state_req != state_q;
	logic req_legal;
	always_comb
	begin
		case (LINK.state_req)
			ST_INIT: req_legal = 1'b1;
			ST_PREOP: req_legal = (state_q == ST_INIT && mbx_cfg_ok) || pd_ok;
			ST_SAFE_OPERATIONAL_STATE: req_legal = (state_q == ST_PREOP && pd_cfg_ok) || state_q == ST_OP;
			ST_OP: req_legal = state_q == ST_SAFE_OPERATIONAL_STATE;
			ST_BOOT: req_legal = state_q == ST_INIT;
			default: req_legal = 1'b0;
		endcase
	end
	wire take = req_new && req_legal;
	wire entering_safe = take && LINK.state_req == ST_SAFE_OPERATIONAL_STATE && state_q == ST_PREOP;

	// output selection
	// timer zero frees safe_operational_state outputs
	wire out_live = (state_q == ST_OP || (state_q == ST_SAFE_OPERATIONAL_STATE && bus_wd_q == 16'h0000))
		&& !bus_exp_q && !lpi_exp_q;
	wire [PD_W-1:0] out_d = out_live ? out_data_q : safe_val_q;

	// registers; timer and multiplier start-up values come from parameters so a bench can shorten them
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			mult_q <= MULT_RESET;
			lpi_wd_q <= LPI_WD_RESET;
			bus_wd_q <= BUS_WD_RESET;
			sync_cfg_q <= SYNC_CFG_RST;
			safe_val_q <= SAFE_VAL_RST;
		end
		else
		begin
			if (wr_mult)
				mult_q <= LINK.reg_wdata;
			if (wr_lpi)
				lpi_wd_q <= LINK.reg_wdata;
			if (wr_bus)
				bus_wd_q <= LINK.reg_wdata;
			if (wr_sync)
				sync_cfg_q <= LINK.reg_wdata[2:0];
			if (wr_safe)
				safe_val_q <= LINK.reg_wdata[PD_W-1:0];
		end
	end

	// prescaler runs free, so a restart lands up to one tick early
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
			pre_q <= 17'h00000;
		else if (tick || pre_q >= tick_len)
			pre_q <= 17'h00000;
		else
			pre_q <= pre_q + 17'h00001;
	end

	// the two watchdogs
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			bus_cnt_q <= 16'h0000;
			lpi_cnt_q <= 16'h0000;
			bus_exp_q <= 1'b0;
			lpi_exp_q <= 1'b0;
		end
		else
		begin
			bus_cnt_q <= wd_next(bus_cnt_q, bus_kick, tick, bus_exp_q);
			lpi_cnt_q <= wd_next(lpi_cnt_q, lpi_kick, tick, lpi_exp_q);
			bus_exp_q <= wd_exp(bus_cnt_q, bus_wd_q, bus_kick, tick, bus_exp_q);
			lpi_exp_q <= wd_exp(lpi_cnt_q, lpi_wd_q, lpi_kick, tick, lpi_exp_q);
		end
	end

	// input pins pass two flops before use
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			in_s1_q <= 8'h00;
			in_s2_q <= 8'h00;
		end
		else
		begin
			in_s1_q <= IN_I;
			in_s2_q <= in_s1_q;
		end
	end

	// state machine and process data
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			state_q <= ST_INIT;
			req_err_q <= 1'b0;
			out_data_q <= SAFE_VAL_RST;
			pd_in_q <= 8'h00;
		end
		else
		begin
			if (take)
				state_q <= LINK.state_req;
			req_err_q <= req_new && !req_legal;
			if (bus_kick)
				out_data_q <= LINK.pd_out;
			// inputs copied as safe_operational_state is acknowledged
			if (pd_ok || entering_safe)
				pd_in_q <= in_s2_q;
		end
	end

	// registered status and pins
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			OUT_O <= SAFE_VAL_RST;
			MBX_EN_O <= 1'b0;
			FILE_XFER_ONLY_O <= 1'b0;
			PD_EN_O <= 1'b0;
			BUS_WD_EXP_O <= 1'b0;
			LPI_WD_EXP_O <= 1'b0;
			LINK.reg_rdata <= 16'h0000;
		end
		else
		begin
			OUT_O <= out_d;
			MBX_EN_O <= mbx_ok;
			FILE_XFER_ONLY_O <= state_q == ST_BOOT;
			PD_EN_O <= pd_ok;
			BUS_WD_EXP_O <= bus_exp_q;
			LPI_WD_EXP_O <= lpi_exp_q;
			if (!LINK.reg_re)
				LINK.reg_rdata <= 16'h0000;
			else
			begin
				case (LINK.reg_addr)
					REG_STATUS: LINK.reg_rdata <= {9'h000, req_err_q, lpi_exp_q, bus_exp_q,
						1'b0, state_q};
					REG_MULT: LINK.reg_rdata <= mult_q;
					REG_LPI_WD: LINK.reg_rdata <= lpi_wd_q;
					REG_BUS_WD: LINK.reg_rdata <= bus_wd_q;
					REG_SYNC_CFG: LINK.reg_rdata <= {13'h0000, sync_cfg_q};
					REG_SAFE_VAL: LINK.reg_rdata <= {8'h00, safe_val_q};
					default: LINK.reg_rdata <= 16'h0000;
				endcase
			end
		end
	end

	assign STATE_O = state_q;
	assign LINK.state_cur = state_q;
	assign LINK.pd_in = pd_in_q;
endmodule

/* hw/swd_pkg.sv */
package swd_pkg;
	// device register offsets, as seen over the bus-side register port
	localparam logic [11:0] REG_STATUS = 12'h130;
	localparam logic [11:0] REG_MULT = 12'h400;
	localparam logic [11:0] REG_LPI_WD = 12'h410;
	localparam logic [11:0] REG_BUS_WD = 12'h420;
	localparam logic [11:0] REG_SYNC_CFG = 12'h800;
	localparam logic [11:0] REG_SAFE_VAL = 12'h810;
	// register reset values
	localparam logic [15:0] MULT_RST = 16'h09c2;
	localparam logic [15:0] BUS_WD_RST = 16'h03e8;
	localparam logic [15:0] LPI_WD_RST = 16'h03e8;
	localparam logic [2:0] SYNC_CFG_RST = 3'h0;
	localparam logic [7:0] SAFE_VAL_RST = 8'h00;
	// sync channel configuration bits
	localparam int SYNC_CH0_BIT = 0;
	localparam int SYNC_CH1_BIT = 1;
	localparam int SYNC_CH2_BIT = 2;
	// status register fields
	localparam int STAT_BUS_EXP_BIT = 4;
	localparam int STAT_LPI_EXP_BIT = 5;
	localparam int STAT_REQ_ERR_BIT = 6;
	// timing: base tick from the clock rate, watchdog tick adds two base ticks
	localparam int CLK_FREQ_HZ = 25000000;
	localparam int BASE_TICK_NS = 40;
	localparam int BASE_TICK_CYCLES = (BASE_TICK_NS * (CLK_FREQ_HZ / 1000000)) / 1000;
	localparam logic [16:0] TICK_EXTRA = 17'h00002;
	localparam int DEFAULT_TIMEOUT_MS = 100;
	// process data width
	localparam int PD_W = 8;
	// master-side software register offsets
	localparam logic [3:0] M_CTRL = 4'h0;
	localparam logic [3:0] M_MULT = 4'h1;
	localparam logic [3:0] M_LPI = 4'h2;
	localparam logic [3:0] M_BUS = 4'h3;
	localparam logic [3:0] M_REQ = 4'h4;
	localparam logic [3:0] M_OUT = 4'h5;
	localparam logic [3:0] M_STAT = 4'h6;
	localparam logic [3:0] M_RADDR = 4'h7;
	localparam logic [3:0] M_RDATA = 4'h8;
	localparam int CTRL_DL_EN_BIT = 0;
	localparam int CTRL_START_BIT = 1;
	// slave state machine states
	typedef enum logic [2:0] {ST_INIT, ST_PREOP, ST_SAFE_OPERATIONAL_STATE, ST_OP, ST_BOOT} swd_state_type;
endpackage

/* hw/swd_if.sv */
`timescale 1ns/10ps
interface swd_if;
	import swd_pkg::*;
	// register port, read data one cycle after the read strobe
	logic [11:0] reg_addr;
	logic [15:0] reg_wdata;
	logic reg_we;
	logic reg_re;
	logic [15:0] reg_rdata;
	// process data exchange
	logic pd_wr;
	logic [PD_W-1:0] pd_out;
	logic [PD_W-1:0] pd_in;
	// state request and current state
	swd_state_type state_req;
	swd_state_type state_cur;

	modport master (output reg_addr, reg_wdata, reg_we, reg_re, pd_wr, pd_out, state_req,
		input reg_rdata, pd_in, state_cur);
	modport device (input reg_addr, reg_wdata, reg_we, reg_re, pd_wr, pd_out, state_req,
		output reg_rdata, pd_in, state_cur);
endinterface

/* hw/swd_bus_master.sv */
`timescale 1ns/10ps
module swd_bus_master
	import swd_pkg::*;
(
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_I,
	// software register port
	input wire logic [3:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WE_I,
	input wire logic RE_I,
	output logic [15:0] RDATA_O,
	// link to the slave controller
	swd_if.master LINK
);
	typedef enum logic [2:0] {M_IDLE, M_DL0, M_DL1, M_DL2, M_PD, M_SEND} swd_mstate_type;

	swd_mstate_type st_q;
	logic dl_en_q;
	logic [15:0] mult_q, lpi_q, bus_q, rd_q;
	logic [PD_W-1:0] out_q;
	swd_state_type want_q;
	logic pd_pend_q, req_pend_q;
	// a remote read asked for while the sequencer is busy waits here
	logic rd_pend_q, raddr_pend_q;
	logic [11:0] raddr_q;

	// software write decode
	wire wr_ctrl = WE_I && (ADDR_I == M_CTRL);
	wire wr_req = WE_I && (ADDR_I == M_REQ);
	wire wr_out = WE_I && (ADDR_I == M_OUT);
	wire wr_raddr = WE_I && (ADDR_I == M_RADDR);
	wire start_dl = wr_ctrl && WDATA_I[CTRL_DL_EN_BIT] && WDATA_I[CTRL_START_BIT];
	wire [15:0] stat_word = {3'h0, LINK.pd_in, 2'h0, LINK.state_cur};

	// software registers; a request for op also queues an output write first
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			dl_en_q <= 1'b0;
			mult_q <= MULT_RST;
			lpi_q <= LPI_WD_RST;
			bus_q <= BUS_WD_RST;
			out_q <= SAFE_VAL_RST;
			want_q <= ST_INIT;
			rd_q <= 16'h0000;
		end
		else
		begin
			if (wr_ctrl)
				dl_en_q <= WDATA_I[CTRL_DL_EN_BIT];
			if (WE_I && ADDR_I == M_MULT)
				mult_q <= WDATA_I;
			if (WE_I && ADDR_I == M_LPI)
				lpi_q <= WDATA_I;
			if (WE_I && ADDR_I == M_BUS)
				bus_q <= WDATA_I;
			if (wr_out)
				out_q <= WDATA_I[PD_W-1:0];
			if (wr_req)
				want_q <= swd_state_type'(WDATA_I[2:0]);
			// remote read data lands one cycle after the strobe
			if (LINK.reg_re)
				rd_q <= 16'h0000;
			else if (rd_pend_q)
				rd_q <= LINK.reg_rdata;
		end
	end

	// link sequencer: download, output write, state request
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			st_q <= M_IDLE;
			pd_pend_q <= 1'b0;
			req_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			raddr_pend_q <= 1'b0;
			raddr_q <= 12'h000;
			LINK.reg_addr <= 12'h000;
			LINK.reg_wdata <= 16'h0000;
			LINK.reg_we <= 1'b0;
			LINK.reg_re <= 1'b0;
			LINK.pd_wr <= 1'b0;
			LINK.pd_out <= SAFE_VAL_RST;
			LINK.state_req <= ST_INIT;
		end
		else
		begin
			LINK.reg_we <= 1'b0;
			LINK.reg_re <= 1'b0;
			LINK.pd_wr <= 1'b0;
			rd_pend_q <= LINK.reg_re;
			if (wr_out)
				pd_pend_q <= 1'b1;
			if (wr_req)
				req_pend_q <= 1'b1;
			if (wr_raddr)
			begin
				raddr_pend_q <= 1'b1;
				raddr_q <= WDATA_I[11:0];
			end
			case (st_q)
				M_IDLE:
				begin
					if (start_dl)
						st_q <= M_DL0;
					else if (raddr_pend_q)
					begin
						LINK.reg_addr <= raddr_q;
						LINK.reg_re <= 1'b1;
						raddr_pend_q <= wr_raddr;
					end
					else if (pd_pend_q)
						st_q <= M_PD;
					else if (req_pend_q)
						st_q <= (want_q == ST_OP) ? M_PD : M_SEND;
				end
				M_DL0:
				begin
					LINK.reg_addr <= REG_MULT;
					LINK.reg_wdata <= mult_q;
					LINK.reg_we <= 1'b1;
					st_q <= M_DL1;
				end
				M_DL1:
				begin
					LINK.reg_addr <= REG_LPI_WD;
					LINK.reg_wdata <= lpi_q;
					LINK.reg_we <= 1'b1;
					st_q <= M_DL2;
				end
				M_DL2:
				begin
					LINK.reg_addr <= REG_BUS_WD;
					LINK.reg_wdata <= bus_q;
					LINK.reg_we <= 1'b1;
					st_q <= M_IDLE;
				end
				M_PD:
				begin
					LINK.pd_out <= out_q;
					LINK.pd_wr <= 1'b1;
					pd_pend_q <= wr_out;
					st_q <= req_pend_q ? M_SEND : M_IDLE;
				end
				M_SEND:
				begin
					LINK.state_req <= want_q;
					req_pend_q <= wr_req;
					st_q <= M_IDLE;
				end
				default:
					st_q <= M_IDLE;
			endcase
		end
	end

	// software read data, one cycle after the strobe
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
			RDATA_O <= 16'h0000;
		else if (RE_I)
		begin
			case (ADDR_I)
				M_CTRL: RDATA_O <= {15'h0000, dl_en_q};
				M_MULT: RDATA_O <= mult_q;
				M_LPI: RDATA_O <= lpi_q;
				M_BUS: RDATA_O <= bus_q;
				M_REQ: RDATA_O <= {13'h0000, want_q};
				M_OUT: RDATA_O <= {8'h00, out_q};
				M_STAT: RDATA_O <= stat_word;
				M_RDATA: RDATA_O <= rd_q;
				default: RDATA_O <= 16'h0000;
			endcase
		end
		else
			RDATA_O <= 16'h0000;
	end
endmodule

/* verification/swd_link_monitor.sv */
`timescale 1ns/10ps
module swd_link_monitor
	import swd_pkg::*;
#(
	parameter logic [15:0] MULT_RESET = MULT_RST,
	parameter logic [15:0] BUS_WD_RESET = BUS_WD_RST
)
(
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_I,
	// link signals
	input wire logic [11:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	input wire logic [15:0] reg_rdata,
	input wire logic [PD_W-1:0] pd_in,
	input wire swd_state_type state_req,
	input wire swd_state_type state_cur
);
	// shadows of the last writes, so read data can be predicted
	logic [15:0] mult_q;
	logic [15:0] bus_q;
	logic [2:0] sync_q;
	wire logic rd_mult = reg_re && reg_addr == REG_MULT;
	wire logic rd_bus = reg_re && reg_addr == REG_BUS_WD;
	wire logic mbx_ok = sync_q[SYNC_CH0_BIT] && sync_q[SYNC_CH1_BIT];

	// writes land one cycle later in the device, same as here
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			mult_q <= MULT_RESET;
			bus_q <= BUS_WD_RESET;
			sync_q <= SYNC_CFG_RST;
		end
		else if (reg_we)
		begin
			if (reg_addr == REG_MULT)
				mult_q <= reg_wdata;
			if (reg_addr == REG_BUS_WD)
				bus_q <= reg_wdata;
			if (reg_addr == REG_SYNC_CFG)
				sync_q <= reg_wdata[2:0];
		end
	end

	default clocking mon_cb @(posedge CLOCK_I);
	endclocking
	default disable iff (RST_I);

	// register port answers
	a_rdata_slot_only: assert property (!$past(reg_re) |-> reg_rdata == 16'h0000)
		else $error("read data outside its slot");
	a_mult_read_back: assert property ($past(rd_mult) |-> reg_rdata == mult_q)
		else $error("multiplier read back wrong");
	a_bus_read_back: assert property ($past(rd_bus) |-> reg_rdata == bus_q)
		else $error("bus timer read back wrong");
	// state moves
	a_init_after_reset: assert property ($past(RST_I) |-> state_cur == ST_INIT)
		else $error("state not init after reset");
	a_move_on_request: assert property (
		$changed(state_cur) |-> $past(state_req) == state_cur)
		else $error("state moved without request");
	a_boot_from_init: assert property (
		$changed(state_cur) && state_cur == ST_BOOT |-> $past(state_cur) == ST_INIT)
		else $error("boot entered from wrong state");
	a_boot_exits_init: assert property (
		$changed(state_cur) && $past(state_cur) == ST_BOOT |-> state_cur == ST_INIT)
		else $error("boot left to wrong state");
	a_preop_refused: assert property (
		state_cur == ST_INIT && state_req == ST_PREOP && !mbx_ok |=> state_cur == ST_INIT)
		else $error("preop taken without mailbox setup");
	// input image frozen while no process data may flow
	a_inputs_frozen: assert property (
		(state_cur inside {ST_INIT, ST_PREOP, ST_BOOT})[*3] |-> $stable(pd_in))
		else $error("input image moved without process data");

	c_boot_entry: cover property (state_cur == ST_BOOT);
	c_preop_refused: cover property (state_cur == ST_INIT && state_req == ST_PREOP);
	c_mult_read: cover property ($past(rd_mult));
endmodule

/* verification/testbench.sv */
`timescale 1ns/10ps
module testbench
	import swd_pkg::*;
;
	// clock, reset and the master's software port
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] sw_addr = 4'h0;
	logic [15:0] sw_wdata = 16'h0000;
	logic sw_we = 1'b0;
	logic sw_re = 1'b0;
	logic [15:0] sw_rdata;
	// driven inputs and observed outputs of both slaves
	logic lpi2 = 1'b0;
	logic [PD_W-1:0] in2 = 8'h5a;
	logic [PD_W-1:0] out2;
	swd_state_type st1;
	swd_state_type st2;
	logic fx1;
	logic mbx2;
	logic pde2;
	logic bexp2;
	logic lexp2;
	int err_count = 0;
	int samples_checked = 0;

	// first link joins master and slave, the second is driven by the bench
	swd_if link_if();
	swd_if bench_if();

	always #20 clk = ~clk;

	swd_bus_master swd_bus_master_inst (
		.CLOCK_I(clk), .RST_I(rst), .ADDR_I(sw_addr), .WDATA_I(sw_wdata),
		.WE_I(sw_we), .RE_I(sw_re), .RDATA_O(sw_rdata), .LINK(link_if.master)
	);
	swd_slave_controller swd_slave_controller_inst (
		.CLOCK_I(clk), .RST_I(rst), .LINK(link_if.device), .IN_I(in2),
		.LPI_ACCESS_I(1'b0), .OUT_O(), .STATE_O(st1), .MBX_EN_O(),
		.FILE_XFER_ONLY_O(fx1), .PD_EN_O(), .BUS_WD_EXP_O(), .LPI_WD_EXP_O()
	);
	// short tick and counts keep expiry runs to a few hundred cycles
	swd_slave_controller #(.MULT_RESET(16'h0002), .BUS_WD_RESET(16'h0040),
		.LPI_WD_RESET(16'h0000)) swd_slave_controller_inst_b (
		.CLOCK_I(clk), .RST_I(rst), .LINK(bench_if.device), .IN_I(in2),
		.LPI_ACCESS_I(lpi2), .OUT_O(out2), .STATE_O(st2), .MBX_EN_O(mbx2),
		.FILE_XFER_ONLY_O(), .PD_EN_O(pde2), .BUS_WD_EXP_O(bexp2), .LPI_WD_EXP_O(lexp2)
	);
	swd_link_monitor #(.MULT_RESET(MULT_RST), .BUS_WD_RESET(BUS_WD_RST)) swd_link_monitor_inst (
		.CLOCK_I(clk), .RST_I(rst), .reg_addr(link_if.reg_addr),
		.reg_wdata(link_if.reg_wdata), .reg_we(link_if.reg_we), .reg_re(link_if.reg_re),
		.reg_rdata(link_if.reg_rdata), .pd_in(link_if.pd_in),
		.state_req(link_if.state_req), .state_cur(link_if.state_cur)
	);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		if (err_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// software port of the master: one-cycle strobes
	task automatic sw_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_we <= 1'b1;
		@(posedge clk);
		sw_we <= 1'b0;
	endtask
	task automatic sw_rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		sw_addr <= a;
		sw_re <= 1'b1;
		@(posedge clk);
		sw_re <= 1'b0;
		#1;
		chk(sw_rdata, e);
	endtask
	// eight cycles covers a read queued behind a three-write download
	task automatic rr(input logic [11:0] a, input logic [15:0] e);
		sw_wr(M_RADDR, {4'h0, a});
		repeat (8) @(posedge clk);
		sw_rd(M_RDATA, e);
	endtask
	task automatic req1(input swd_state_type s, input swd_state_type e);
		sw_wr(M_REQ, 16'(s));
		repeat (8) @(posedge clk);
		#1;
		chk(16'(st1), 16'(e));
	endtask

	// device port of the bench-driven slave
	task automatic dv_wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk);
		bench_if.reg_addr <= a;
		bench_if.reg_wdata <= d;
		bench_if.reg_we <= 1'b1;
		@(posedge clk);
		bench_if.reg_we <= 1'b0;
	endtask
	task automatic dv_rd(input logic [11:0] a, input logic [15:0] e);
		@(posedge clk);
		bench_if.reg_addr <= a;
		bench_if.reg_re <= 1'b1;
		@(posedge clk);
		bench_if.reg_re <= 1'b0;
		#1;
		chk(bench_if.reg_rdata, e);
	endtask
	task automatic go(input swd_state_type s);
		@(posedge clk);
		bench_if.state_req <= s;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic pd(input logic [7:0] d);
		@(posedge clk);
		bench_if.pd_out <= d;
		bench_if.pd_wr <= 1'b1;
		@(posedge clk);
		bench_if.pd_wr <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	initial
	begin
		bench_if.reg_addr = 12'h000;
		bench_if.reg_wdata = 16'h0000;
		bench_if.reg_we = 1'b0;
		bench_if.reg_re = 1'b0;
		bench_if.pd_wr = 1'b0;
		bench_if.pd_out = 8'h00;
		bench_if.state_req = ST_INIT;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		// defaults, then a download without and with its enable
		rr(REG_MULT, MULT_RST);
		rr(REG_BUS_WD, BUS_WD_RST);
		sw_wr(M_MULT, 16'h0010);
		sw_wr(M_BUS, 16'hffff);
		sw_wr(M_CTRL, 16'h0002);
		rr(REG_MULT, MULT_RST);
		sw_wr(M_CTRL, 16'h0003);
		rr(REG_MULT, 16'h0010);
		rr(REG_BUS_WD, 16'hffff);
		rr(REG_LPI_WD, LPI_WD_RST);
		sw_rd(M_CTRL, 16'h0001);
		// master-driven moves: boot, refusals
		req1(ST_BOOT, ST_BOOT);
		chk({15'h0000, fx1}, 16'h0001);
		sw_rd(M_STAT, 16'h0004);
		req1(ST_PREOP, ST_BOOT);
		req1(ST_INIT, ST_INIT);
		req1(ST_PREOP, ST_INIT);
		rr(REG_STATUS, 16'h0040);
		// bench-driven slave climbs to op
		chk({11'h000, st2, mbx2, pde2}, {11'h000, ST_INIT, 2'b00});
		dv_rd(REG_MULT, 16'h0002);
		dv_rd(12'h444, 16'h0000);
		dv_wr(REG_SAFE_VAL, 16'h00a5);
		dv_wr(REG_SYNC_CFG, 16'h0007);
		go(ST_PREOP);
		chk({11'h000, st2, mbx2, pde2}, {11'h000, ST_PREOP, 2'b10});
		go(ST_SAFE_OPERATIONAL_STATE);
		chk({8'h00, bench_if.pd_in}, 16'h005a);
		@(posedge clk);
		in2 <= 8'hc3;
		repeat (4) @(posedge clk);
		#1;
		chk({8'h00, bench_if.pd_in}, 16'h00c3);
		pd(8'h3c);
		chk({out2, 3'h0, st2, mbx2, pde2}, {8'ha5, 3'h0, ST_SAFE_OPERATIONAL_STATE, 2'b11});
		go(ST_OP);
		chk({8'h00, out2}, 16'h003c);
		// bus side falls silent: expiry near 64 ticks of 4 cycles, then recovery
		repeat (235) @(posedge clk);
		chk({15'h0000, bexp2}, 16'h0000);
		repeat (30) @(posedge clk);
		chk({out2, 7'h00, bexp2}, 16'ha501);
		chk(16'(st2), 16'(ST_OP));
		pd(8'h66);
		chk({out2, 7'h00, bexp2}, 16'h6600);
		dv_wr(REG_BUS_WD, 16'h0000);
		repeat (300) @(posedge clk);
		chk({out2, 7'h00, bexp2}, 16'h6600);
		go(ST_SAFE_OPERATIONAL_STATE);
		chk({8'h00, out2}, 16'h0066);
		// local watchdog trips on its own and clears on a local access
		dv_wr(REG_LPI_WD, 16'h0003);
		repeat (20) @(posedge clk);
		chk({out2, 6'h00, lexp2, bexp2}, 16'ha502);
		@(posedge clk);
		lpi2 <= 1'b1;
		@(posedge clk);
		lpi2 <= 1'b0;
		@(posedge clk);
		#1;
		chk({15'h0000, lexp2}, 16'h0000);
		go(ST_BOOT);
		chk(16'(st2), 16'(ST_SAFE_OPERATIONAL_STATE));
		test_done;
	end

	// hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		test_done;
	end
endmodule
